// ---- hdl/nid_consts.vh ----
/*
  constants for the local node address register block: offset, field
  positions, reset values. assumes nothing; definitions only.
*/
`ifndef NID_CONSTS_VH
`define NID_CONSTS_VH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define NID_ADDR_W            8
`define NID_LOCAL_NODE_OFS    8'hE8

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define NID_VALID_BIT         31
`define NID_ROOT_BIT          30
`define NID_CPWR_BIT          27
`define NID_SEG_HI            15
`define NID_SEG_LO            6
`define NID_SEG_W             10
`define NID_IDX_HI            5
`define NID_IDX_LO            0
`define NID_IDX_W             6
`define NID_IDX_BCAST         6'h3F

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define NID_SEG_RST           10'h000
`define NID_IDX_RST           6'h00
`define NID_RESP_OKAY         2'h0
`define NID_RESP_SLVERR       2'h2

`endif

// ---- hdl/nid_sync2.v ----
/*
  two flip-flop synchroniser for a vector of levels from the phy side.
  assumes the bits are slow levels or held until sampled.
*/
`timescale 1ns/100ps
`include "nid_consts.vh"

module nid_sync2 #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_r;
  reg [W-1:0] q_r;

  // first stage feeds only the second stage
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q_r    <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;

endmodule // nid_sync2

// ---- hdl/nid_node_addr.v ----
/*
  local node address register behind an axi4-lite slave. holds the bus
  segment number (software), node index (loaded from the phy), and the
  address valid, root and cable power flags.
  a phy pin change shows in the register three edges later; a write
  answers two edges after both halves arrive, a read one edge after ar.
  assumes phy pins are asynchronous levels; the index load strobe is held
  by the phy for at least three ref_clk cycles together with its data.
*/
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "nid_consts.vh"

module nid_node_addr (
  input  wire                   ref_clk,
  input  wire                   rst_n,
  // axi4-lite slave
  input  wire [`NID_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output wire [1:0]             s_axi_bresp,
  output wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`NID_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output wire [31:0]            s_axi_rdata,
  output wire [1:0]             s_axi_rresp,
  output wire                   s_axi_rvalid,
  input  wire                   s_axi_rready,
  // phy side, asynchronous levels
  input  wire                   phy_bus_reset,
  input  wire                   phy_is_root,
  input  wire                   phy_cable_power_ok,
  input  wire                   phy_index_load,
  input  wire [`NID_IDX_W-1:0]  phy_node_index,
  // status out
  output wire [15:0]            node_id,
  output wire                   node_index_bcast
);

  // ----------------------------------------------------------------------
  // phy input synchronisation
  // ----------------------------------------------------------------------
  // all phy levels share one synchroniser so that a load and its index,
  // or a bus reset and the root level, stay aligned cycle for cycle
  localparam SW = 4 + `NID_IDX_W;
  wire [SW-1:0] phy_s;

  nid_sync2 #(.W(SW)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       ({phy_bus_reset, phy_is_root, phy_cable_power_ok, phy_index_load,
               phy_node_index}),
    .q       (phy_s)
  );

  wire                  bus_reset_s = phy_s[SW-1];
  wire                  is_root_s   = phy_s[SW-2];
  wire                  cpwr_s      = phy_s[SW-3];
  wire                  load_s      = phy_s[SW-4];
  wire [`NID_IDX_W-1:0] index_s     = phy_s[`NID_IDX_W-1:0];

  // the load strobe acts on its synchronised rising edge only; a level
  // still high after a bus reset ends does not reload a stale index
  reg load_d_r;
  wire load_rise = load_s & ~load_d_r;

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  reg                  valid_r;
  reg                  root_r;
  reg                  cpwr_r;
  reg [`NID_SEG_W-1:0] seg_r;
  reg [`NID_IDX_W-1:0] idx_r;

  // write channel holding: address and data may arrive in either order
  reg                   aw_have_r;
  reg [`NID_ADDR_W-1:0] aw_addr_r;
  reg                   w_have_r;
  reg [31:0]            w_data_r;
  reg [3:0]             w_strb_r;
  reg                   bvalid_r;
  reg [1:0]             bresp_r;
  reg                   rvalid_r;
  reg [31:0]            rdata_r;
  reg [1:0]             rresp_r;

  // readies are combinational from held state: one write and one read at
  // a time, and no new address while an answer waits for its ready
  assign s_axi_awready = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready  = ~w_have_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // address bits 1:0 are ignored: the register is one aligned word
  wire do_write = aw_have_r & w_have_r & ~bvalid_r;
  wire wr_hit   = ({aw_addr_r[`NID_ADDR_W-1:2], 2'h0} == `NID_LOCAL_NODE_OFS);
  wire rd_hit   = ({s_axi_araddr[`NID_ADDR_W-1:2], 2'h0} == `NID_LOCAL_NODE_OFS);

  // read image: reserved bits stay zero
  wire [31:0] reg_image;
  assign reg_image = {valid_r, root_r, 2'b00, cpwr_r, 11'h000,
                      seg_r, idx_r};

  assign node_id          = {seg_r, idx_r};
  assign node_index_bcast = (idx_r == `NID_IDX_BCAST);

  // ----------------------------------------------------------------------
  // hardware updated flags and index
  // ----------------------------------------------------------------------
  // bus reset wins over a load in the same cycle: an index from before the
  // reset is stale by definition
  // root tracks the phy only while bus reset is seen and holds afterwards;
  // cable power is a plain follower, one edge behind the synchroniser
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      load_d_r <= 1'b0;
      valid_r  <= 1'b0;
      root_r   <= 1'b0;
      cpwr_r   <= 1'b0;
      idx_r    <= `NID_IDX_RST;
    end else begin
      load_d_r <= load_s;
      cpwr_r   <= cpwr_s;
      if (bus_reset_s) begin
        valid_r <= 1'b0;
        root_r  <= is_root_s;
      end else if (load_rise) begin
        valid_r <= 1'b1;
        idx_r   <= index_s;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------------
  // only the segment field takes data; its two bytes obey byte lanes
  // flags, index and reserved bits ignore written data
  // a strobe of zero still answers okay and leaves the register as it was
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= {`NID_ADDR_W{1'b0}};
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `NID_RESP_OKAY;
      seg_r     <= `NID_SEG_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? `NID_RESP_OKAY : `NID_RESP_SLVERR;
        if (wr_hit) begin
          if (w_strb_r[0])
            seg_r[1:0] <= w_data_r[7:6];
          if (w_strb_r[1])
            seg_r[`NID_SEG_W-1:2] <= w_data_r[`NID_SEG_HI:8];
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------------
  // unmapped addresses answer slverr with zero data
  // rdata is a snapshot taken when ar is accepted and stands until rready
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `NID_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      if (rd_hit) begin
        rdata_r <= reg_image;
        rresp_r <= `NID_RESP_OKAY;
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= `NID_RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // nid_node_addr

// ---- verif/nid_node_addr_props.sv ----
/* assertions on the ports of nid_node_addr.
   assumes phy levels are held as long as the block needs them. */
`timescale 1ns/100ps
module nid_node_addr_props (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        phy_bus_reset,
  input wire        phy_is_root,
  input wire        phy_cable_power_ok,
  input wire        phy_index_load,
  input wire [5:0]  phy_node_index,
  input wire [15:0] node_id,
  input wire        node_index_bcast
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a good read of the register has just been answered
  sequence s_rd;
    $rose(s_axi_rvalid) && s_axi_rresp == 2'h0;
  endsequence
  property p_rsvd;
    s_axi_rvalid |-> s_axi_rdata[29:28] == 2'h0 && s_axi_rdata[26:16] == 11'h000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_id;
    s_rd ##0 $stable(node_id) |-> s_axi_rdata[15:0] == node_id;
  endproperty
  a_id: assert property (p_id) else $error("node id differs from read");
  // pins are judged a few edges back: they cross two flops first
  property p_rst;
    s_rd ##0 $past(phy_bus_reset, 4) && $past(phy_bus_reset, 7) &&
      $past(phy_is_root, 4) == $past(phy_is_root, 7)
      |-> !s_axi_rdata[31] && s_axi_rdata[30] == $past(phy_is_root, 4);
  endproperty
  a_rst: assert property (p_rst) else $error("flags wrong in bus reset");
  property p_cp;
    s_rd ##0 $past(phy_cable_power_ok, 4) == $past(phy_cable_power_ok, 7)
      |-> s_axi_rdata[27] == $past(phy_cable_power_ok, 4);
  endproperty
  a_cp: assert property (p_cp) else $error("power flag wrong");
  property p_idx;
    $rose(phy_index_load) && !phy_bus_reset ##1
      (phy_index_load && !phy_bus_reset && $stable(phy_node_index)) [*4]
      |-> node_id[5:0] == phy_node_index;
  endproperty
  a_idx: assert property (p_idx) else $error("index not loaded");
  property p_bc;
    node_id[5:0] == 6'h3F && $past(node_id[5:0]) == 6'h3F |-> node_index_bcast;
  endproperty
  a_bc: assert property (p_bc) else $error("index 63 not flagged");
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write answer repeated");
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read answer repeated");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_bc: cover property (node_index_bcast);
endmodule // nid_node_addr_props

bind nid_node_addr nid_node_addr_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .phy_bus_reset(phy_bus_reset), .phy_is_root(phy_is_root),
  .phy_cable_power_ok(phy_cable_power_ok), .phy_index_load(phy_index_load),
  .phy_node_index(phy_node_index), .node_id(node_id), .node_index_bcast(node_index_bcast));

// ---- verif/nid_phy_model.sv ----
/* stand-in for the attached phy: bus reset, root, power, index load.
   assumes one bench process calls drive, right after a clock edge. */
`timescale 1ns/100ps
module nid_phy_model (
  input  wire        ref_clk,
  output logic       phy_bus_reset,
  output logic       phy_is_root,
  output logic       phy_cable_power_ok,
  output logic       phy_index_load,
  output logic [5:0] phy_node_index
);
  // -------
  // drivers
  // -------
  initial {phy_bus_reset, phy_is_root, phy_cable_power_ok, phy_index_load,
           phy_node_index} = 10'h000;
  // v = {bus reset, root, power good, load, index}, held for n edges
  task automatic drive(input logic [9:0] v, input int n);
    @(posedge ref_clk);
    {phy_bus_reset, phy_is_root, phy_cable_power_ok, phy_index_load, phy_node_index} <= v;
    repeat (n) @(posedge ref_clk);
  endtask
endmodule // nid_phy_model

// ---- verif/tb.sv ----
/* bench for nid_node_addr: axi4-lite master, phy model, table of writes.
   assumes only the files of this block around it. */
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb;
  // -------
  // signals
  // -------
  logic        ref_clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic        bre = 1'b0, rre = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rd_q;
  logic [3:0]  ws = 4'h0;
  logic [1:0]  rs_q;
  wire         awr, wrr, arr, bv, rv, pbr, prt, pcp, pld, bc;
  wire [1:0]   br, rr;
  wire [31:0]  rd;
  wire [15:0]  nid;
  wire [5:0]   pix;
  int          num_errors = 0, n_compared = 0, i, r;
  // write data, strobes, segment number expected afterwards
  logic [45:0] rows [4] = '{{32'hFFFFFFFF, 4'hF, 10'h3FF}, {32'h0, 4'h1, 10'h3FC},
                            {32'h0000AA40, 4'h2, 10'h2A8}, {32'hFFFFFFFF, 4'h0, 10'h2A8}};
  initial forever #50 ref_clk = ~ref_clk;
  nid_node_addr dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(adr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(adr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .phy_bus_reset(pbr), .phy_is_root(prt), .phy_cable_power_ok(pcp),
    .phy_index_load(pld), .phy_node_index(pix), .node_id(nid), .node_index_bcast(bc));
  nid_phy_model phy (.ref_clk(ref_clk), .phy_bus_reset(pbr), .phy_is_root(prt),
    .phy_cable_power_ok(pcp), .phy_index_load(pld), .phy_node_index(pix));
  // f = {valid, root, power}
  function automatic logic [31:0] word(input logic [2:0] f, input logic [15:0] id);
    return {f[2:1], 2'h0, f[0], 11'h000, id};
  endfunction
  task automatic report_and_stop;
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus transfer; each channel is dropped at the edge that takes it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge ref_clk);
    {adr, wd, ws} <= {a, d, s};
    {awv, wv, bre, arv, rre} <= {w, w, w, !w, !w};
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
      if (arr) arv <= 1'b0;
      if (bv || rv) break;
    end
    if (i == 40) begin
      num_errors++;
      report_and_stop;
    end
    {rd_q, rs_q} = {rd, w ? br : rr};
    {bre, rre} <= 2'h0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
    xfer(1'b1, a, d, s);
    `CHK("bresp", er, rs_q)
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    xfer(1'b0, a, 32'h0, 4'h0);
    `CHK("rdata", e, rd_q)
    `CHK("rresp", er, rs_q)
  endtask
  // -------------
  // main sequence
  // -------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(8'hE8, 32'h0, 2'h0);
    chk(8'hE4, 32'h0, 2'h2);
    phy.drive(10'h3AA, 8);
    phy.drive(10'h095, 8);
    phy.drive(10'h0C5, 6);
    phy.drive(10'h0BA, 4);
    chk(8'hE8, word(3'h7, 16'h0005), 2'h0);
    `CHK("bcast", 1'b0, bc)
    for (r = 0; r < 4; r++) begin
      wreg(8'hE8, rows[r][45:14], rows[r][13:10], 2'h0);
      chk(8'hE8, word(3'h7, {rows[r][9:0], 6'h05}), 2'h0);
    end
    wreg(8'hEC, 32'hFFFFFFFF, 4'hF, 2'h2);
    phy.drive(10'h2AA, 8);
    chk(8'hE8, word(3'h1, 16'hAA05), 2'h0);
    phy.drive(10'h195, 8);
    phy.drive(10'h17F, 6);
    phy.drive(10'h100, 4);
    chk(8'hE8, word(3'h4, 16'hAA3F), 2'h0);
    `CHK("node_id", 16'hAA3F, nid)
    `CHK("bcast", 1'b1, bc)
    // mid-run reset: segment, index and flags all return to zero
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(8'hE8, 32'h0, 2'h0);
    `CHK("node_id", 16'h0000, nid)
    `CHK("bcast", 1'b0, bc)
    report_and_stop;
  end
endmodule // tb
